/* rtl/flc_cyc_engine.sv */
/*
  Bus cycle engine: runs one read or write strobe cycle on the flash pins.
  Assumes the flash data input is synchronous to clk_sys_i.
*/
`timescale 1ns/10ps
`include "flc_defs.svh"
module flc_cyc_engine (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  flc_cyc_if.engine cyc,
  output logic [`FLC_AW-1:0] flash_addr_o,
  output logic [`FLC_DW-1:0] flash_dq_o,
  output logic flash_dq_oe_o,
  input wire logic [`FLC_DW-1:0] flash_dq_i,
  output logic flash_ce_n_o,
  output logic flash_oe_n_o,
  output logic flash_we_n_o
);
  import flc_pkg::*;

  localparam int SETUP_CYC = (`FLC_T_SETUP_NS * `FLC_CLK_MHZ + 999) / 1000;
  localparam int PULSE_CYC = (`FLC_T_PULSE_NS * `FLC_CLK_MHZ + 999) / 1000;
  localparam int HOLD_CYC = (`FLC_T_HOLD_NS * `FLC_CLK_MHZ + 999) / 1000;

  flc_cyc_state_t st_r, st_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic wr_r, wr_nxt;
  logic [`FLC_AW-1:0] addr_r, addr_nxt;
  logic [`FLC_DW-1:0] wd_r, wd_nxt, rd_r, rd_nxt;
  logic oe_r, oe_nxt, ce_n_r, ce_n_nxt, oe_n_r, oe_n_nxt, we_n_r, we_n_nxt;
  logic done_r, done_nxt;

  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r + 8'h01;
    wr_nxt = wr_r;
    addr_nxt = addr_r;
    wd_nxt = wd_r;
    rd_nxt = rd_r;
    oe_nxt = oe_r;
    ce_n_nxt = ce_n_r;
    oe_n_nxt = oe_n_r;
    we_n_nxt = we_n_r;
    done_nxt = 1'b0;
    case (st_r)
      FLC_C_IDLE:
      begin
        cnt_nxt = 8'h00;
        if (cyc.req)
        begin
          st_nxt = FLC_C_SETUP;
          wr_nxt = cyc.wr;
          addr_nxt = cyc.addr;
          wd_nxt = cyc.wdata;
          ce_n_nxt = 1'b0;
          // Drive data only on writes, never while the flash reads out
          oe_nxt = cyc.wr;
        end
      end
      FLC_C_SETUP:
        if (cnt_r == 8'(SETUP_CYC - 1))
        begin
          st_nxt = FLC_C_STROBE;
          cnt_nxt = 8'h00;
          we_n_nxt = ~wr_r;
          oe_n_nxt = wr_r;
        end
      FLC_C_STROBE:
        if (cnt_r == 8'(PULSE_CYC - 1))
        begin
          st_nxt = FLC_C_HOLD;
          cnt_nxt = 8'h00;
          we_n_nxt = 1'b1;
          oe_n_nxt = 1'b1;
          if (!wr_r)
            rd_nxt = flash_dq_i;
        end
      FLC_C_HOLD:
        if (cnt_r == 8'(HOLD_CYC - 1))
        begin
          // Deselect between cycles so every read is a fresh access
          st_nxt = FLC_C_IDLE;
          ce_n_nxt = 1'b1;
          oe_nxt = 1'b0;
          done_nxt = 1'b1;
        end
      default: st_nxt = FLC_C_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      st_r <= FLC_C_IDLE;
      cnt_r <= 8'h00;
      wr_r <= 1'b0;
      addr_r <= `FLC_ADDR_ZERO;
      wd_r <= 8'h00;
      rd_r <= 8'h00;
      oe_r <= 1'b0;
      ce_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      we_n_r <= 1'b1;
      done_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      wr_r <= wr_nxt;
      addr_r <= addr_nxt;
      wd_r <= wd_nxt;
      rd_r <= rd_nxt;
      oe_r <= oe_nxt;
      ce_n_r <= ce_n_nxt;
      oe_n_r <= oe_n_nxt;
      we_n_r <= we_n_nxt;
      done_r <= done_nxt;
    end
  end

  assign cyc.done = done_r;
  assign cyc.rdata = rd_r;
  assign flash_addr_o = addr_r;
  assign flash_dq_o = wd_r;
  assign flash_dq_oe_o = oe_r;
  assign flash_ce_n_o = ce_n_r;
  assign flash_oe_n_o = oe_n_r;
  assign flash_we_n_o = we_n_r;
endmodule

/* rtl/flc_cyc_if.sv */
/*
  Link between the sequencer and the bus cycle engine.
  Assumes one clock; req is a one-cycle pulse taken only while idle.
*/
`timescale 1ns/10ps
`include "flc_defs.svh"
interface flc_cyc_if;
  logic req;
  logic wr;
  logic [`FLC_AW-1:0] addr;
  logic [`FLC_DW-1:0] wdata;
  logic done;
  logic [`FLC_DW-1:0] rdata;

  modport master (output req, output wr, output addr, output wdata, input done, input rdata);
  modport engine (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

/* rtl/flc_defs.svh */
/*
  Constants for the parallel flash host controller: command codes,
  unlock addresses, status bit positions and timing figures.
  Assumes a byte-wide flash with 20 address bits.
*/
`ifndef FLC_DEFS_SVH
`define FLC_DEFS_SVH

`define FLC_CLK_MHZ 100
`define FLC_AW 20
`define FLC_DW 8

// Unlock and command addresses, only bits 14..0 matter to the flash
`define FLC_ADDR_UNLK1 20'h05555
`define FLC_ADDR_UNLK2 20'h02aaa
`define FLC_ADDR_ZERO 20'h00000
`define FLC_SECTOR_MASK 20'hff000
`define FLC_BLOCK_MASK 20'hf0000

`define FLC_D_UNLK1 8'haa
`define FLC_D_UNLK2 8'h55
`define FLC_D_PROG 8'ha0
`define FLC_D_ERASE 8'h80
`define FLC_D_ID_ENTRY 8'h90
`define FLC_D_QUERY_ENTRY 8'h98
`define FLC_D_EXIT 8'hf0
`define FLC_D_SECTOR 8'h30
`define FLC_D_BLOCK 8'h50
`define FLC_D_CHIP 8'h10

// Last step index of each sequence
`define FLC_LAST_PROG 3'h3
`define FLC_LAST_ERASE 3'h5
`define FLC_LAST_ENTRY 3'h2
`define FLC_LAST_EXIT 3'h0

`define FLC_POLL_BIT 7
`define FLC_TOGGLE_BIT 6

// Bus cycle timing
`define FLC_T_SETUP_NS 10
`define FLC_T_PULSE_NS 90
`define FLC_T_HOLD_NS 20
// Settle after completion (least) and program timeout (longest)
`define FLC_T_SETTLE_NS 1000
`define FLC_T_PROG_MAX_NS 20000
`define FLC_ERASE_TMO_CYC 10000000

`endif

/* rtl/flc_host.sv */
/*
  Host controller for a byte-wide parallel flash: issues protected command
  sequences, polls completion status and tracks identification/query mode.
  Assumes a synchronous user command port and flash inputs on clk_sys_i.
*/
`timescale 1ns/10ps
`include "flc_defs.svh"
module flc_host #(
  parameter int ERASE_TMO_CYC = `FLC_ERASE_TMO_CYC
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic cmd_valid_i,
  input wire flc_pkg::flc_op_t cmd_op_i,
  input wire logic [`FLC_AW-1:0] cmd_addr_i,
  input wire logic [`FLC_DW-1:0] cmd_data_i,
  output logic cmd_ready_o,
  output logic rsp_valid_o,
  output logic [`FLC_DW-1:0] rsp_data_o,
  output logic rsp_err_o,
  output logic id_mode_o,
  output logic query_mode_o,
  output logic [`FLC_AW-1:0] flash_addr_o,
  output logic [`FLC_DW-1:0] flash_dq_o,
  output logic flash_dq_oe_o,
  input wire logic [`FLC_DW-1:0] flash_dq_i,
  output logic flash_ce_n_o,
  output logic flash_oe_n_o,
  output logic flash_we_n_o
);
  import flc_pkg::*;

  localparam int SETTLE_CYC = (`FLC_T_SETTLE_NS * `FLC_CLK_MHZ + 999) / 1000;
  localparam int PROG_TMO_CYC = (`FLC_T_PROG_MAX_NS * `FLC_CLK_MHZ) / 1000;

  flc_cyc_if cyc ();

  flc_cyc_engine u_engine (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .cyc(cyc.engine),
    .flash_addr_o(flash_addr_o),
    .flash_dq_o(flash_dq_o),
    .flash_dq_oe_o(flash_dq_oe_o),
    .flash_dq_i(flash_dq_i),
    .flash_ce_n_o(flash_ce_n_o),
    .flash_oe_n_o(flash_oe_n_o),
    .flash_we_n_o(flash_we_n_o)
  );

  flc_state_t st_r, st_nxt;
  flc_op_t op_r, op_nxt;
  logic [`FLC_AW-1:0] addr_r, addr_nxt, caddr_r, caddr_nxt;
  logic [`FLC_DW-1:0] data_r, data_nxt, cdata_r, cdata_nxt, prev_r, prev_nxt;
  logic [`FLC_DW-1:0] rsp_r, rsp_nxt;
  logic [2:0] step_r, step_nxt;
  logic [23:0] cnt_r, cnt_nxt;
  logic conf_r, conf_nxt, req_r, req_nxt, wr_r, wr_nxt;
  logic ready_r, ready_nxt, rv_r, rv_nxt, err_r, err_nxt;
  logic id_r, id_nxt, qry_r, qry_nxt;
  logic [2:0] last_step;
  logic [23:0] tmo_lim;
  logic poll_ok;

  // One write of a protected sequence: address and data for a step
  function automatic logic [`FLC_AW+`FLC_DW-1:0] seq_word(input flc_op_t op,
                                                       input logic [2:0] s,
                                                       input logic [`FLC_AW-1:0] a,
                                                       input logic [`FLC_DW-1:0] d);
    logic [`FLC_AW+`FLC_DW-1:0] w;
    w = {`FLC_ADDR_UNLK1, `FLC_D_UNLK1};
    if (op == FLC_OP_EXIT)
      w = {`FLC_ADDR_ZERO, `FLC_D_EXIT};
    else if (s == 3'h1 || s == 3'h4)
      w = {`FLC_ADDR_UNLK2, `FLC_D_UNLK2};
    else if (s == 3'h2)
    begin
      case (op)
        FLC_OP_PROG: w = {`FLC_ADDR_UNLK1, `FLC_D_PROG};
        FLC_OP_ID: w = {`FLC_ADDR_UNLK1, `FLC_D_ID_ENTRY};
        FLC_OP_QUERY: w = {`FLC_ADDR_UNLK1, `FLC_D_QUERY_ENTRY};
        default: w = {`FLC_ADDR_UNLK1, `FLC_D_ERASE};
      endcase
    end
    else if (s == 3'h3 && op == FLC_OP_PROG)
      w = {a, d};
    else if (s == 3'h5)
    begin
      case (op)
        FLC_OP_SECTOR: w = {a & `FLC_SECTOR_MASK, `FLC_D_SECTOR};
        FLC_OP_BLOCK: w = {a & `FLC_BLOCK_MASK, `FLC_D_BLOCK};
        default: w = {`FLC_ADDR_UNLK1, `FLC_D_CHIP};
      endcase
    end
    return w;
  endfunction

  always_comb
  begin
    case (op_r)
      FLC_OP_PROG: last_step = `FLC_LAST_PROG;
      FLC_OP_ID, FLC_OP_QUERY: last_step = `FLC_LAST_ENTRY;
      FLC_OP_EXIT: last_step = `FLC_LAST_EXIT;
      default: last_step = `FLC_LAST_ERASE;
    endcase
    tmo_lim = (op_r == FLC_OP_PROG) ? 24'(PROG_TMO_CYC) : 24'(ERASE_TMO_CYC);
    // Program: poll bit true data; erase: poll bit reads one when done
    if (op_r == FLC_OP_PROG)
      poll_ok = cyc.rdata[`FLC_POLL_BIT] == data_r[`FLC_POLL_BIT];
    else
      poll_ok = cyc.rdata[`FLC_POLL_BIT];
  end

  always_comb
  begin
    st_nxt = st_r;
    op_nxt = op_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    caddr_nxt = caddr_r;
    cdata_nxt = cdata_r;
    prev_nxt = prev_r;
    rsp_nxt = rsp_r;
    step_nxt = step_r;
    cnt_nxt = (cnt_r == 24'hffffff) ? cnt_r : cnt_r + 24'h000001;
    conf_nxt = conf_r;
    req_nxt = 1'b0;
    wr_nxt = wr_r;
    rv_nxt = 1'b0;
    err_nxt = err_r;
    id_nxt = id_r;
    qry_nxt = qry_r;
    case (st_r)
      FLC_S_IDLE:
        if (cmd_valid_i && ready_r)
        begin
          op_nxt = cmd_op_i;
          addr_nxt = cmd_addr_i;
          data_nxt = cmd_data_i;
          step_nxt = 3'h0;
          err_nxt = 1'b0;
          req_nxt = 1'b1;
          if (cmd_op_i == FLC_OP_READ)
          begin
            st_nxt = FLC_S_RD;
            wr_nxt = 1'b0;
            caddr_nxt = cmd_addr_i;
          end
          else
          begin
            // Every alteration goes out with its unlock writes
            st_nxt = FLC_S_SEQ;
            wr_nxt = 1'b1;
            {caddr_nxt, cdata_nxt} = seq_word(cmd_op_i, 3'h0, cmd_addr_i, cmd_data_i);
          end
        end
      FLC_S_SEQ:
        if (cyc.done)
        begin
          req_nxt = 1'b1;
          if (step_r == last_step)
          begin
            wr_nxt = 1'b0;
            caddr_nxt = addr_r;
            cnt_nxt = 24'h000000;
            case (op_r)
              FLC_OP_ID: id_nxt = 1'b1;
              FLC_OP_QUERY: qry_nxt = 1'b1;
              FLC_OP_EXIT:
              begin
                id_nxt = 1'b0;
                qry_nxt = 1'b0;
              end
              default: ;
            endcase
            if (op_r == FLC_OP_ID || op_r == FLC_OP_QUERY || op_r == FLC_OP_EXIT)
            begin
              st_nxt = FLC_S_IDLE;
              req_nxt = 1'b0;
              rv_nxt = 1'b1;
            end
            else
              st_nxt = FLC_S_POLL_A;
          end
          else
          begin
            step_nxt = step_r + 3'h1;
            {caddr_nxt, cdata_nxt} = seq_word(op_r, step_r + 3'h1, addr_r, data_r);
          end
        end
      FLC_S_RD:
        if (cyc.done)
        begin
          rsp_nxt = cyc.rdata;
          rv_nxt = 1'b1;
          st_nxt = FLC_S_IDLE;
        end
      FLC_S_POLL_A, FLC_S_POLL_B, FLC_S_CONFIRM:
        if (cyc.done)
        begin
          req_nxt = 1'b1;
          prev_nxt = cyc.rdata;
          conf_nxt = 1'b0;
          if (cnt_r >= tmo_lim)
          begin
            st_nxt = FLC_S_IDLE;
            req_nxt = 1'b0;
            rv_nxt = 1'b1;
            err_nxt = 1'b1;
            rsp_nxt = cyc.rdata;
          end
          else if (st_r == FLC_S_POLL_A)
            st_nxt = FLC_S_POLL_B;
          else if (cyc.rdata[`FLC_TOGGLE_BIT] != prev_r[`FLC_TOGGLE_BIT])
            st_nxt = FLC_S_POLL_B;
          else if (st_r == FLC_S_POLL_B)
            st_nxt = FLC_S_CONFIRM;
          else if (!poll_ok)
            st_nxt = FLC_S_POLL_B;
          else if (!conf_r)
            conf_nxt = 1'b1;
          else
          begin
            st_nxt = FLC_S_SETTLE;
            req_nxt = 1'b0;
            cnt_nxt = 24'h000000;
          end
        end
      FLC_S_SETTLE:
        if (cnt_r == 24'(SETTLE_CYC - 1))
        begin
          // Whole byte only trusted after the settle time
          st_nxt = FLC_S_RD;
          req_nxt = 1'b1;
        end
      default: st_nxt = FLC_S_IDLE;
    endcase
    // No new command until the internal operation has ended or its status poll has timed out
    ready_nxt = (st_nxt == FLC_S_IDLE);
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      st_r <= FLC_S_IDLE;
      op_r <= FLC_OP_READ;
      addr_r <= `FLC_ADDR_ZERO;
      data_r <= 8'h00;
      caddr_r <= `FLC_ADDR_ZERO;
      cdata_r <= 8'h00;
      prev_r <= 8'h00;
      rsp_r <= 8'h00;
      step_r <= 3'h0;
      cnt_r <= 24'h000000;
      conf_r <= 1'b0;
      req_r <= 1'b0;
      wr_r <= 1'b0;
      ready_r <= 1'b0;
      rv_r <= 1'b0;
      err_r <= 1'b0;
      id_r <= 1'b0;
      qry_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      caddr_r <= caddr_nxt;
      cdata_r <= cdata_nxt;
      prev_r <= prev_nxt;
      rsp_r <= rsp_nxt;
      step_r <= step_nxt;
      cnt_r <= cnt_nxt;
      conf_r <= conf_nxt;
      req_r <= req_nxt;
      wr_r <= wr_nxt;
      ready_r <= ready_nxt;
      rv_r <= rv_nxt;
      err_r <= err_nxt;
      id_r <= id_nxt;
      qry_r <= qry_nxt;
    end
  end

  assign cyc.req = req_r;
  assign cyc.wr = wr_r;
  assign cyc.addr = caddr_r;
  assign cyc.wdata = cdata_r;
  assign cmd_ready_o = ready_r;
  assign rsp_valid_o = rv_r;
  assign rsp_data_o = rsp_r;
  assign rsp_err_o = err_r;
  assign id_mode_o = id_r;
  assign query_mode_o = qry_r;
endmodule

/* rtl/flc_pkg.sv */
/*
  Types for the parallel flash host controller.
  Assumes flc_defs.svh for the numeric constants.
*/
package flc_pkg;
  typedef enum logic [2:0] {
    FLC_OP_READ = 3'h0,
    FLC_OP_PROG = 3'h1,
    FLC_OP_SECTOR = 3'h2,
    FLC_OP_BLOCK = 3'h3,
    FLC_OP_CHIP = 3'h4,
    FLC_OP_ID = 3'h5,
    FLC_OP_QUERY = 3'h6,
    FLC_OP_EXIT = 3'h7
  } flc_op_t;

  typedef enum logic [6:0] {
    FLC_S_IDLE = 7'h01,
    FLC_S_SEQ = 7'h02,
    FLC_S_RD = 7'h04,
    FLC_S_POLL_A = 7'h08,
    FLC_S_POLL_B = 7'h10,
    FLC_S_CONFIRM = 7'h20,
    FLC_S_SETTLE = 7'h40
  } flc_state_t;

  typedef enum logic [3:0] {
    FLC_C_IDLE = 4'h1,
    FLC_C_SETUP = 4'h2,
    FLC_C_STROBE = 4'h4,
    FLC_C_HOLD = 4'h8
  } flc_cyc_state_t;
endpackage

/* sim/flc_flash_model.sv */
/*
  Behavioural byte-wide flash with unlock sequences and status polling.
  Assumes strobes from the host; busy_ns set by the bench.
*/
`timescale 1ns/10ps
module flc_flash_model #(
  parameter logic [7:0] MAKER_CODE = 8'h3c, // Arbitrary value
  parameter logic [7:0] PART_CODE = 8'h7e // Arbitrary value
) (
  input wire logic [19:0] addr_i,
  input wire logic [7:0] dq_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  output logic [7:0] dq_o,
  output logic dq_en_o
);
  logic [7:0] mem [int];
  logic [7:0] pdata = 8'h00;
  logic [14:0] a;
  logic tog = 1'b0;
  bit erasing = 1'b0;
  int step = 0;
  int nx;
  int mode = 0;
  int busy_ns = 3000;
  time busy_until = 0;
  int kill [$];
  initial dq_en_o = 1'b0;
  initial dq_o = 8'h00;

  task automatic erase(input logic [19:0] m);
    kill.delete();
    foreach (mem[k])
      if ((k & m) == (addr_i & m)) kill.push_back(k);
    foreach (kill[i]) mem.delete(kill[i]);
    erasing = 1'b1;
    busy_until = $time + busy_ns;
  endtask

  // Command decode on the closing edge of each write made outside the busy time
  always @(posedge we_n_i)
    if (ce_n_i == 1'b0 && $time >= busy_until)
    begin
      a = addr_i[14:0];
      nx = 0;
      if (step == 0 && dq_i == 8'hf0) mode = 0;
      if ((step == 0 || step == 3) && a == 15'h5555 && dq_i == 8'haa) nx = step + 1;
      if ((step == 1 || step == 4) && a == 15'h2aaa && dq_i == 8'h55) nx = step + 1;
      if (step == 2 && a == 15'h5555)
      begin
        if (dq_i == 8'ha0) nx = 9;
        if (dq_i == 8'h80) nx = 3;
        if (dq_i == 8'h90) mode = 1;
        if (dq_i == 8'h98) mode = 2;
        if (dq_i == 8'hf0) mode = 0;
      end
      if (step == 5 && dq_i == 8'h30) erase(20'hff000);
      if (step == 5 && dq_i == 8'h50) erase(20'hf0000);
      if (step == 5 && dq_i == 8'h10 && a == 15'h5555) erase(20'h00000);
      if (step == 9)
      begin
        mem[addr_i] = dq_i;
        pdata = dq_i;
        erasing = 1'b0;
        busy_until = $time + busy_ns;
      end
      step = nx;
    end

  always @(negedge oe_n_i)
    if (ce_n_i == 1'b0 && we_n_i == 1'b1)
    begin
      if ($time < busy_until)
      begin
        tog = ~tog;
        dq_o = {erasing ? 1'b0 : ~pdata[7], tog, ~pdata[5:0]};
      end
      else if (mode == 1) dq_o = addr_i[0] ? PART_CODE : MAKER_CODE;
      else if (mode == 2) dq_o = (addr_i[7:0] == 8'h10) ? 8'h51 :
        (addr_i[7:0] == 8'h11) ? 8'h52 : (addr_i[7:0] == 8'h12) ? 8'h59 : 8'h00;
      else dq_o = mem.exists(addr_i) ? mem[addr_i] : 8'hff;
      // Low bits still settling just after completion
      if (busy_until != 0 && $time >= busy_until && $time < busy_until + 1000)
        dq_o[5:0] = ~dq_o[5:0];
      dq_en_o = 1'b1;
    end

  always @(posedge oe_n_i or posedge ce_n_i) dq_en_o = 1'b0;
endmodule

/* sim/flc_host_properties.sv */
/*
  Port checker for the flash host controller.
  Assumes one clock and a bind onto flc_host.
*/
`timescale 1ns/10ps
`include "flc_defs.svh"
module flc_host_properties (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic cmd_valid_i,
  input wire flc_pkg::flc_op_t cmd_op_i,
  input wire logic cmd_ready_o,
  input wire logic rsp_valid_o,
  input wire logic rsp_err_o,
  input wire logic id_mode_o,
  input wire logic query_mode_o,
  input wire logic [`FLC_AW-1:0] flash_addr_o,
  input wire logic [`FLC_DW-1:0] flash_dq_o,
  input wire logic flash_dq_oe_o,
  input wire logic flash_ce_n_o,
  input wire logic flash_oe_n_o,
  input wire logic flash_we_n_o
);
  import flc_pkg::*;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  logic take;
  assign take = cmd_valid_i && cmd_ready_o;

  AST_DQ_OFF_ON_READ: assert property (!flash_oe_n_o |-> !flash_dq_oe_o)
    else $error("host drives data during a read strobe");
  AST_STROBE_SELECTED: assert property ((!flash_we_n_o || !flash_oe_n_o) |-> !flash_ce_n_o)
    else $error("strobe low while deselected");
  AST_WE_WIDTH: assert property ($fell(flash_we_n_o) |-> (!flash_we_n_o)[*8] ##1 !flash_we_n_o ##1 flash_we_n_o)
    else $error("write strobe width wrong");
  AST_WE_STABLE: assert property (!flash_we_n_o && !$fell(flash_we_n_o)
    |-> $stable(flash_addr_o) && $stable(flash_dq_o))
    else $error("address or data moved under write strobe");
  AST_WE_DRIVES: assert property ($fell(flash_we_n_o) |-> flash_dq_oe_o)
    else $error("write strobe without data drive");
  AST_CE_GAP: assert property ($rose(flash_ce_n_o) |=> flash_ce_n_o)
    else $error("no deselect gap between bus cycles");
  AST_TAKE_BUSY: assert property (take |=> !cmd_ready_o)
    else $error("ready stayed high after a take");
  AST_READ_LAT: assert property (take && cmd_op_i == FLC_OP_READ |-> ##[12:16] rsp_valid_o)
    else $error("read response late");
  AST_EXIT_CLEARS: assert property (take && cmd_op_i == FLC_OP_EXIT
    |-> ##[1:30] (!id_mode_o && !query_mode_o))
    else $error("mode flags not cleared by exit");
  AST_ERR_WITH_RSP: assert property ($rose(rsp_err_o) |-> rsp_valid_o)
    else $error("error flag without response");
  cover property (take && cmd_op_i == FLC_OP_PROG);
  cover property (rsp_valid_o && rsp_err_o);
  cover property ($fell(query_mode_o));
endmodule
bind flc_host flc_host_properties i_flc_host_properties (.clk_sys_i, .sys_rst_i, .cmd_valid_i,
  .cmd_op_i, .cmd_ready_o, .rsp_valid_o, .rsp_err_o, .id_mode_o, .query_mode_o, .flash_addr_o,
  .flash_dq_o, .flash_dq_oe_o, .flash_ce_n_o, .flash_oe_n_o, .flash_we_n_o);

/* sim/flc_host_tb_top.sv */
/*
  Self-checking bench for the flash host controller with a flash model.
  Assumes flc_host, flc_flash_model and the bound checker.
*/
`timescale 1ns/10ps
module flc_host_tb_top;
  import flc_pkg::*;
  localparam logic [7:0] MAKER = 8'h3c; // Arbitrary value
  localparam logic [7:0] PART = 8'h7e; // Arbitrary value
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  flc_op_t cmd_op_i = FLC_OP_READ;
  logic [19:0] cmd_addr_i = 20'h00000;
  logic [7:0] cmd_data_i = 8'h00;
  logic cmd_ready_o, rsp_valid_o, rsp_err_o, id_mode_o, query_mode_o, men;
  logic [7:0] rsp_data_o, flash_dq_o, flash_dq_i, mdq, got, d;
  logic [7:0] bus_last = 8'h00;
  logic [19:0] flash_addr_o;
  logic flash_dq_oe_o, flash_ce_n_o, flash_oe_n_o, flash_we_n_o, gerr;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [7:0] exp_mem [int];
  logic [19:0] pa [4];
  logic [7:0] qexp [3] = '{8'h51, 8'h52, 8'h59};
  flc_op_t e_op [3] = '{FLC_OP_SECTOR, FLC_OP_BLOCK, FLC_OP_CHIP};
  logic [19:0] e_a [3] = '{20'h11abc, 20'h10000, 20'h00000};
  logic [19:0] e_m [3] = '{20'hff000, 20'hf0000, 20'h00000};
  int kill [$];

  always #5 clk_sys_i = ~clk_sys_i;
  // Undriven bus shows the inverse of its last level
  assign flash_dq_i = flash_dq_oe_o ? flash_dq_o : (men ? mdq : ~bus_last);
  always @*
    if (flash_dq_oe_o) bus_last = flash_dq_o;
    else if (men) bus_last = mdq;

  flc_host #(.ERASE_TMO_CYC(2000)) i_flc_host (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i),
    .cmd_data_i(cmd_data_i), .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o),
    .rsp_data_o(rsp_data_o), .rsp_err_o(rsp_err_o), .id_mode_o(id_mode_o),
    .query_mode_o(query_mode_o), .flash_addr_o(flash_addr_o), .flash_dq_o(flash_dq_o),
    .flash_dq_oe_o(flash_dq_oe_o), .flash_dq_i(flash_dq_i), .flash_ce_n_o(flash_ce_n_o),
    .flash_oe_n_o(flash_oe_n_o), .flash_we_n_o(flash_we_n_o));
  flc_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) i_flc_flash_model (
    .addr_i(flash_addr_o), .dq_i(flash_dq_i), .ce_n_i(flash_ce_n_o), .oe_n_i(flash_oe_n_o),
    .we_n_i(flash_we_n_o), .dq_o(mdq), .dq_en_o(men));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic run(input flc_op_t op, input logic [19:0] a, input logic [7:0] dat);
    @(negedge clk_sys_i);
    cmd_valid_i = 1'b1;
    cmd_op_i = op;
    cmd_addr_i = a;
    cmd_data_i = dat;
    // Ready is looked at off the edge; the next rising edge takes it
    while (cmd_ready_o !== 1'b1) @(negedge clk_sys_i);
    @(negedge clk_sys_i);
    cmd_valid_i = 1'b0;
    while (rsp_valid_o !== 1'b1) @(negedge clk_sys_i);
    got = rsp_data_o;
    gerr = rsp_err_o;
  endtask

  function automatic logic [7:0] ref_rd(input logic [19:0] a);
    return exp_mem.exists(a) ? exp_mem[a] : 8'hff;
  endfunction

  task automatic rd_chk(input string what, input logic [19:0] a);
    run(FLC_OP_READ, a, 8'h00);
    chk(what, ref_rd(a), got);
  endtask

  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_count++;
      $display("[ERR] watchdog expected finish seen hang");
      tally_and_finish();
    end
  end

  initial
  begin
    void'($urandom(32'he471e060));
    repeat (12) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    chk("ce_n idle", 8'h01, {7'h00, flash_ce_n_o});
    run(FLC_OP_ID, 20'h00000, 8'h00);
    chk("id mode", 8'h01, {7'h00, id_mode_o});
    run(FLC_OP_READ, 20'h00000, 8'h00);
    chk("maker code", MAKER, got);
    run(FLC_OP_READ, 20'h00001, 8'h00);
    chk("part code", PART, got);
    run(FLC_OP_EXIT, 20'h00000, 8'h00);
    chk("id mode off", 8'h00, {7'h00, id_mode_o});
    rd_chk("array after exit", 20'h00001);
    $display("test ident done");
    run(FLC_OP_QUERY, 20'h00000, 8'h00);
    chk("query mode", 8'h01, {7'h00, query_mode_o});
    for (int i = 0; i < 3; i++)
    begin
      run(FLC_OP_READ, 20'h00010 + 20'(i), 8'h00);
      chk("query table", qexp[i], got);
    end
    run(FLC_OP_EXIT, 20'h00000, 8'h00);
    chk("query mode off", 8'h00, {7'h00, query_mode_o});
    $display("test query done");
    pa = '{20'h11234, 20'h15678, {4'h2, 16'($urandom)}, {4'h3, 16'($urandom)}};
    foreach (pa[i])
    begin
      d = 8'($urandom);
      i_flc_flash_model.busy_ns = 2000 + i * 1000;
      run(FLC_OP_PROG, pa[i], d);
      exp_mem[pa[i]] = d;
      chk("program status", d, got);
      rd_chk("program readback", pa[i]);
    end
    $display("test program done");
    i_flc_flash_model.busy_ns = 8000;
    for (int j = 0; j < 3; j++)
    begin
      run(e_op[j], e_a[j], 8'h00);
      chk("erase status", 8'hff, got);
      kill.delete();
      foreach (exp_mem[k])
        if ((k & e_m[j]) == (e_a[j] & e_m[j])) kill.push_back(k);
      foreach (kill[i]) exp_mem.delete(kill[i]);
      foreach (pa[i]) rd_chk("erase extent", pa[i]);
    end
    $display("test erase done");
    i_flc_flash_model.busy_ns = 30000;
    run(FLC_OP_SECTOR, pa[2], 8'h00);
    chk("slow erase error", 8'h01, {7'h00, gerr});
    repeat (3000) @(negedge clk_sys_i);
    rd_chk("after slow erase", pa[2]);
    chk("error cleared", 8'h00, {7'h00, gerr});
    $display("test timeout done");
    tally_and_finish();
  end
endmodule
